// File: logic/opad_params.svh
// Contract
// - Addressing mode 11 makes the operand-select field a register number, not a memory form.
// - Mode 00 gives zero displacement and no displacement bytes, except in the direct form.
// - Addressing mode 01 takes one displacement byte, sign-extended to 16 bits.
// - Addressing mode 10 takes two displacement bytes, high byte above low byte.
// - Memory forms 000 to 111 add the displacement to the listed base and index sums.
// - Mode 00 with operand-select 110 takes the offset directly from two displacement bytes.
// - Displacement bytes follow the addressing byte and come before any immediate bytes.
// - A segment-override prefix field decodes as extra, code, stack, data for 00 to 11.
// - Register numbers map to word registers, or with size clear to low then high bytes.
// - Operands whose offset uses the frame pointer default to the stack segment.
// - String destinations through the destination index always use the extra segment.
// - Sign-extended immediate opcodes take one byte and widen it to a word.
// - The opcode direction bit routes the result toward or away from the register operand.
// - After the escape opcode a second opcode byte is decoded before the addressing byte.
`ifndef OPAD_PARAMS_SVH
`define OPAD_PARAMS_SVH
`define OPAD_CTRL_OFS 12'h000
`define OPAD_STAT_OFS 12'h004
`define OPAD_DCNT_OFS 12'h008
`define OPAD_UCNT_OFS 12'h00C
`define OPAD_LAST_OFS 12'h010
`define OPAD_CTRL_EN_BIT 0
`define OPAD_CTRL_PROT_BIT 1
`define OPAD_CTRL_RST 2'h1
`define OPAD_MOD_NODISP 2'h0
`define OPAD_MOD_DISP8 2'h1
`define OPAD_MOD_DISP16 2'h2
`define OPAD_MOD_REG 2'h3
`define OPAD_RM_DIRECT 3'h6
`define OPAD_ESC_OP 8'h0F
`endif

// File: logic/opad_pkg.sv
package opad_pkg;
    typedef enum logic [2:0] {
        OPAD_IDLE = 3'h0,
        OPAD_SECOND = 3'h1,
        OPAD_MODRM = 3'h3,
        OPAD_DISP_LO = 3'h2,
        OPAD_DISP_HI = 3'h6,
        OPAD_IMM_LO = 3'h7,
        OPAD_IMM_HI = 3'h5,
        OPAD_DONE = 3'h4
    } opad_state_t;
    typedef enum logic [1:0] {
        OPAD_SEG_EXTRA = 2'h0,
        OPAD_SEG_CODE = 2'h1,
        OPAD_SEG_STACK = 2'h2,
        OPAD_SEG_DATA = 2'h3
    } opad_seg_t;
    typedef struct packed {
        logic has_modrm;
        logic [1:0] imm_bytes;
        logic imm_sext;
        logic word;
        logic dir;
        logic string_dest;
        logic undefined;
    } opad_attr_t;
    typedef struct packed {
        logic [15:0] base_word;
        logic [15:0] frame_pointer;
        logic [15:0] source_index;
        logic [15:0] destination_index;
    } opad_regs_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic escaped;
        logic [7:0] second;
        logic is_register;
        logic [2:0] reg_field;
        logic [2:0] rm_field;
        logic [2:0] reg_word;
        logic reg_high;
        logic [2:0] rm_word;
        logic rm_high;
        logic word;
        logic result_to_register;
        logic [15:0] displacement;
        logic [15:0] operand_location;
        opad_seg_t segment;
        logic [15:0] immediate;
        logic undefined;
    } opad_decode_t;
endpackage : opad_pkg

// File: logic/opad_classify.sv
`timescale 1ns/100ps
`default_nettype none
module opad_classify (
    // Opcode bytes and group selector.
    input wire logic [7:0] opcode,
    input wire logic escaped,
    input wire logic [7:0] second,
    input wire logic [2:0] group_sel,
    input wire logic prot_mode,
    // Attributes.
    output opad_pkg::opad_attr_t attr
);
    always_comb begin
        attr = '0;
        attr.word = opcode[0];
        if (escaped) begin
            attr.word = 1'b1;
            case (second)
                8'h00: begin
                    attr.has_modrm = 1'b1;
                    attr.undefined = !prot_mode || group_sel[2:1] == 2'h3;
                end
                8'h01: begin
                    attr.has_modrm = 1'b1;
                    attr.undefined = group_sel == 3'h5 || group_sel == 3'h7;
                end
                8'h02, 8'h03: begin
                    attr.has_modrm = 1'b1;
                    attr.dir = 1'b1;
                    attr.undefined = !prot_mode;
                end
                8'h06: attr.undefined = 1'b0;
                default: attr.undefined = 1'b1;
            endcase
        end else if (opcode[7:6] == 2'h0 && !opcode[2]) begin
            attr.has_modrm = 1'b1;
            attr.dir = opcode[1];
        end else if (opcode[7:6] == 2'h0 && opcode[2:1] == 2'h2) begin
            attr.imm_bytes = opcode[0] ? 2'h2 : 2'h1;
        end else if (opcode[7:4] == 4'hB) begin
            attr.word = opcode[3];
            attr.imm_bytes = opcode[3] ? 2'h2 : 2'h1;
        end else begin
            case (opcode)
                8'h62, 8'h63, 8'h8D: begin
                    attr.has_modrm = 1'b1;
                    attr.word = 1'b1;
                    attr.dir = opcode != 8'h63;
                end
                8'h68: attr.imm_bytes = 2'h2;
                8'h6A: begin
                    attr.word = 1'b1;
                    attr.imm_bytes = 2'h1;
                    attr.imm_sext = 1'b1;
                end
                8'h69, 8'h6B: begin
                    attr.has_modrm = 1'b1;
                    attr.word = 1'b1;
                    attr.dir = 1'b1;
                    attr.imm_bytes = opcode[1] ? 2'h1 : 2'h2;
                    attr.imm_sext = opcode[1];
                end
                8'h80, 8'h81, 8'h82, 8'h83, 8'hC6, 8'hC7: begin
                    attr.has_modrm = 1'b1;
                    attr.imm_bytes = opcode[1:0] == 2'h1 ? 2'h2 : 2'h1;
                    attr.imm_sext = opcode == 8'h83;
                end
                8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8E: begin
                    attr.has_modrm = 1'b1;
                    attr.dir = opcode[1];
                end
                8'h8F: begin
                    attr.has_modrm = 1'b1;
                    attr.undefined = group_sel != 3'h0;
                end
                8'hA8, 8'hA9: attr.imm_bytes = opcode[0] ? 2'h2 : 2'h1;
                8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAA, 8'hAB, 8'hAE, 8'hAF: attr.string_dest = 1'b1;
                8'hC0, 8'hC1, 8'hD0, 8'hD1, 8'hD2, 8'hD3: begin
                    attr.has_modrm = 1'b1;
                    attr.imm_bytes = opcode[4] ? 2'h0 : 2'h1;
                    attr.undefined = group_sel == 3'h6;
                end
                8'hF6, 8'hF7: begin
                    attr.has_modrm = 1'b1;
                    attr.imm_bytes = group_sel != 3'h0 ? 2'h0 : (opcode[0] ? 2'h2 : 2'h1);
                    attr.undefined = group_sel == 3'h1;
                end
                8'hFE, 8'hFF: begin
                    attr.has_modrm = 1'b1;
                    attr.undefined = group_sel == 3'h7;
                end
                default: attr.has_modrm = 1'b0;
            endcase
        end
    end
endmodule : opad_classify
`default_nettype wire

// File: logic/opad_locate.sv
`timescale 1ns/100ps
`default_nettype none
`include "opad_params.svh"
module opad_locate (
    // Addressing byte fields and displacement.
    input wire logic use_mem,
    input wire logic [1:0] mode,
    input wire logic [2:0] rm,
    input wire logic [15:0] disp,
    input wire opad_pkg::opad_regs_t regs,
    // Segment selection inputs.
    input wire logic ovr_valid,
    input wire opad_pkg::opad_seg_t ovr_seg,
    input wire logic string_dest,
    // Result.
    output logic [15:0] offset,
    output opad_pkg::opad_seg_t seg
);
    logic [15:0] base;
    logic [15:0] index;
    logic stack;
    always_comb begin
        index = 16'h0000;
        stack = rm == 3'h2 || rm == 3'h3 || rm == 3'h6;
        unique case (rm)
            3'h0, 3'h1, 3'h7: base = regs.base_word;
            3'h2, 3'h3, 3'h6: base = regs.frame_pointer;
            3'h4: base = regs.source_index;
            3'h5: base = regs.destination_index;
        endcase
        if (!rm[2]) begin
            index = rm[0] ? regs.destination_index : regs.source_index;
        end
        if (mode == `OPAD_MOD_NODISP && rm == `OPAD_RM_DIRECT) begin
            base = 16'h0000;
            stack = 1'b0;
        end
        offset = use_mem ? base + index + disp : 16'h0000;
        seg = stack ? opad_pkg::OPAD_SEG_STACK : opad_pkg::OPAD_SEG_DATA;
        if (ovr_valid) begin
            seg = ovr_seg;
        end
        // The override cannot redirect a string destination.
        if (string_dest) begin
            offset = regs.destination_index;
            seg = opad_pkg::OPAD_SEG_EXTRA;
        end
    end
endmodule : opad_locate
`default_nettype wire

// File: logic/opad_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "opad_params.svh"

module opad_decoder (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction byte stream from the fetch queue.
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    output logic fetch_ready,
    // Register values from the execution unit.
    input wire opad_pkg::opad_regs_t regs,
    // Decoded instruction toward execution and address generation.
    output logic dec_valid,
    input wire logic dec_ready,
    output opad_pkg::opad_decode_t dec
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    opad_pkg::opad_state_t state;
    opad_pkg::opad_state_t next_state;
    opad_pkg::opad_state_t after_disp;
    opad_pkg::opad_attr_t attr;
    opad_pkg::opad_seg_t ovr_seg;
    opad_pkg::opad_seg_t loc_seg;
    opad_pkg::opad_decode_t build;
    logic ctrl_enable;
    logic prot_mode;
    logic ovr_valid;
    logic escaped;
    logic [7:0] opcode;
    logic [7:0] second;
    logic [7:0] modrm;
    logic [7:0] disp_lo;
    logic [7:0] disp_hi;
    logic [7:0] imm_lo;
    logic [7:0] imm_hi;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [15:0] loc_offset;
    logic [15:0] decode_count;
    logic [15:0] undef_count;
    logic [15:0] last_location;
    logic last_undefined;
    logic take;
    logic handoff;
    logic is_seg_prefix;
    logic is_prefix;
    logic direct;
    logic two_disp;
    logic [1:0] disp_need;
    logic [7:0] cls_opcode;
    logic [7:0] cls_second;
    logic [2:0] cls_group;
    logic cls_escaped;
    logic [31:0] rd_mux;
    logic rd_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte acceptance and prefixes.

    // The stream stalls while a finished instruction waits to be taken.
    assign fetch_ready = ctrl_enable && state != opad_pkg::OPAD_DONE;
    assign take = fetch_valid && fetch_ready;
    assign handoff = dec_valid && dec_ready;
    assign is_seg_prefix = fetch_byte[7:5] == 3'h1 && fetch_byte[2:0] == 3'h6;
    assign is_prefix = is_seg_prefix || fetch_byte == 8'hF0 || fetch_byte[7:1] == 7'h79;

    ////////////////////////////////////////////////////////////////////////////////
    // Opcode attributes, looked at on the byte in flight while it is the opcode.

    assign cls_opcode = state == opad_pkg::OPAD_IDLE ? fetch_byte : opcode;
    assign cls_second = state == opad_pkg::OPAD_SECOND ? fetch_byte : second;
    assign cls_escaped = state == opad_pkg::OPAD_SECOND || escaped;
    assign cls_group = state == opad_pkg::OPAD_MODRM ? fetch_byte[5:3] : modrm[5:3];

    opad_classify u_classify (
        .opcode(cls_opcode),
        .escaped(cls_escaped),
        .second(cls_second),
        .group_sel(cls_group),
        .prot_mode(prot_mode),
        .attr(attr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing: prefixes, opcode, second byte, addressing byte, displacement, immediate.

    assign direct = modrm[7:6] == `OPAD_MOD_NODISP && modrm[2:0] == `OPAD_RM_DIRECT;
    assign two_disp = modrm[7:6] == `OPAD_MOD_DISP16 || direct;
    assign after_disp = attr.imm_bytes != 2'h0 ? opad_pkg::OPAD_IMM_LO : opad_pkg::OPAD_DONE;

    always_comb begin
        disp_need = 2'h0;
        unique case (fetch_byte[7:6])
            `OPAD_MOD_REG: disp_need = 2'h0;
            `OPAD_MOD_DISP8: disp_need = 2'h1;
            `OPAD_MOD_DISP16: disp_need = 2'h2;
            `OPAD_MOD_NODISP: begin
                disp_need = fetch_byte[2:0] == `OPAD_RM_DIRECT ? 2'h2 : 2'h0;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        unique case (state)
            opad_pkg::OPAD_IDLE: begin
                if (take && !is_prefix) begin
                    if (fetch_byte == `OPAD_ESC_OP) begin
                        next_state = opad_pkg::OPAD_SECOND;
                    end else if (attr.has_modrm) begin
                        next_state = opad_pkg::OPAD_MODRM;
                    end else begin
                        next_state = after_disp;
                    end
                end
            end
            opad_pkg::OPAD_SECOND: begin
                if (take) begin
                    next_state = attr.has_modrm ? opad_pkg::OPAD_MODRM : after_disp;
                end
            end
            opad_pkg::OPAD_MODRM: begin
                if (take) begin
                    next_state = |disp_need ? opad_pkg::OPAD_DISP_LO : after_disp;
                end
            end
            opad_pkg::OPAD_DISP_LO: begin
                if (take) begin
                    next_state = two_disp ? opad_pkg::OPAD_DISP_HI : after_disp;
                end
            end
            opad_pkg::OPAD_DISP_HI: begin
                if (take) begin
                    next_state = after_disp;
                end
            end
            opad_pkg::OPAD_IMM_LO: begin
                if (take) begin
                    next_state = attr.imm_bytes[1] ? opad_pkg::OPAD_IMM_HI : opad_pkg::OPAD_DONE;
                end
            end
            opad_pkg::OPAD_IMM_HI: begin
                if (take) begin
                    next_state = opad_pkg::OPAD_DONE;
                end
            end
            opad_pkg::OPAD_DONE: begin
                if (handoff) begin
                    next_state = opad_pkg::OPAD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= opad_pkg::OPAD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction byte capture.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opcode <= 8'h00;
            second <= 8'h00;
            escaped <= 1'b0;
            modrm <= 8'h00;
            disp_lo <= 8'h00;
            disp_hi <= 8'h00;
            imm_lo <= 8'h00;
            imm_hi <= 8'h00;
            ovr_valid <= 1'b0;
            ovr_seg <= opad_pkg::OPAD_SEG_DATA;
        end else if (handoff) begin
            escaped <= 1'b0;
            ovr_valid <= 1'b0;
            modrm <= 8'h00;
        end else if (take) begin
            unique case (state)
                opad_pkg::OPAD_IDLE: begin
                    if (is_seg_prefix) begin
                        ovr_valid <= 1'b1;
                        ovr_seg <= opad_pkg::opad_seg_t'(fetch_byte[4:3]);
                    end else if (!is_prefix) begin
                        opcode <= fetch_byte;
                        escaped <= fetch_byte == `OPAD_ESC_OP;
                    end
                end
                opad_pkg::OPAD_SECOND: second <= fetch_byte;
                opad_pkg::OPAD_MODRM: modrm <= fetch_byte;
                opad_pkg::OPAD_DISP_LO: disp_lo <= fetch_byte;
                opad_pkg::OPAD_DISP_HI: disp_hi <= fetch_byte;
                opad_pkg::OPAD_IMM_LO: imm_lo <= fetch_byte;
                opad_pkg::OPAD_IMM_HI: imm_hi <= fetch_byte;
                opad_pkg::OPAD_DONE: imm_hi <= imm_hi;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Displacement, immediate and operand location.

    always_comb begin
        disp = 16'h0000;
        if (attr.has_modrm) begin
            unique case (modrm[7:6])
                `OPAD_MOD_REG: disp = 16'h0000;
                `OPAD_MOD_NODISP: disp = direct ? {disp_hi, disp_lo} : 16'h0000;
                `OPAD_MOD_DISP8: disp = {{8{disp_lo[7]}}, disp_lo};
                `OPAD_MOD_DISP16: disp = {disp_hi, disp_lo};
            endcase
        end
    end

    always_comb begin
        imm = 16'h0000;
        if (attr.imm_bytes == 2'h2) begin
            imm = {imm_hi, imm_lo};
        end else if (attr.imm_bytes == 2'h1) begin
            imm = {(attr.imm_sext ? {8{imm_lo[7]}} : 8'h00), imm_lo};
        end
    end

    opad_locate u_locate (
        .use_mem(attr.has_modrm && modrm[7:6] != `OPAD_MOD_REG),
        .mode(modrm[7:6]),
        .rm(modrm[2:0]),
        .disp(disp),
        .regs(regs),
        .ovr_valid(ovr_valid),
        .ovr_seg(ovr_seg),
        .string_dest(attr.string_dest),
        .offset(loc_offset),
        .seg(loc_seg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Result assembly; byte registers 4 to 7 are the upper halves of word registers 0 to 3.

    always_comb begin
        build = '0;
        build.opcode = opcode;
        build.escaped = escaped;
        build.second = second;
        build.is_register = attr.has_modrm && modrm[7:6] == `OPAD_MOD_REG;
        build.reg_field = modrm[5:3];
        build.rm_field = modrm[2:0];
        build.reg_word = attr.word ? modrm[5:3] : {1'b0, modrm[4:3]};
        build.reg_high = !attr.word && modrm[5];
        build.rm_word = attr.word ? modrm[2:0] : {1'b0, modrm[1:0]};
        build.rm_high = !attr.word && modrm[2];
        build.word = attr.word;
        build.result_to_register = attr.dir;
        build.displacement = disp;
        build.operand_location = loc_offset;
        build.segment = loc_seg;
        build.immediate = imm;
        build.undefined = attr.undefined;
    end

    // One cycle is spent in the finished state before the result shows, so every
    // decoded field comes straight from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_valid <= 1'b0;
            dec <= '0;
        end else if (handoff) begin
            dec_valid <= 1'b0;
        end else if (state == opad_pkg::OPAD_DONE && !dec_valid) begin
            dec_valid <= 1'b1;
            dec <= build;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Statistics.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decode_count <= 16'h0000;
            undef_count <= 16'h0000;
            last_location <= 16'h0000;
            last_undefined <= 1'b0;
        end else if (handoff) begin
            decode_count <= decode_count + 16'h0001;
            last_location <= dec.operand_location;
            last_undefined <= dec.undefined;
            if (dec.undefined) begin
                undef_count <= undef_count + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, error on an unmapped address.

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OPAD_CTRL_OFS: begin
                rd_mux[`OPAD_CTRL_EN_BIT] = ctrl_enable;
                rd_mux[`OPAD_CTRL_PROT_BIT] = prot_mode;
            end
            `OPAD_STAT_OFS: rd_mux[5:0] = {state, dec_valid, |state, last_undefined};
            `OPAD_DCNT_OFS: rd_mux[15:0] = decode_count;
            `OPAD_UCNT_OFS: rd_mux[15:0] = undef_count;
            `OPAD_LAST_OFS: rd_mux[15:0] = last_location;
            default: rd_hit = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Clearing the enable only stops new bytes; a finished instruction still hands off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_enable <= 1'(`OPAD_CTRL_RST);
            prot_mode <= 1'b0;
        end else if (psel && penable && pwrite && paddr == `OPAD_CTRL_OFS) begin
            ctrl_enable <= pwdata[`OPAD_CTRL_EN_BIT];
            prot_mode <= pwdata[`OPAD_CTRL_PROT_BIT];
        end
    end

endmodule : opad_decoder
`default_nettype wire

// File: testbench/opad_decoder_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module opad_decoder_monitor (
    // Clock, reset and observed ports.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic dec_valid,
    input wire logic dec_ready,
    input wire opad_pkg::opad_decode_t dec
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg_form_a: assert property (dec_valid && dec.is_register |->
        dec.operand_location == 0) else $error("register form with an offset");
    word_map_a: assert property (dec_valid && dec.word |->
        dec.reg_word == dec.reg_field) else $error("word register misnumbered");
    byte_map_a: assert property (dec_valid && !dec.word |->
        {dec.rm_high, dec.rm_word[1:0]} == dec.rm_field) else $error("byte register misnumbered");
    string_dest_a: assert property (dec_valid && dec.opcode == 8'hAA |->
        dec.segment == opad_pkg::OPAD_SEG_EXTRA) else $error("string destination segment");
    imm_sext_a: assert property (dec_valid && dec.opcode == 8'h83 |->
        dec.immediate[15:8] == {8{dec.immediate[7]}}) else $error("immediate not widened");
    dir_bit_a: assert property (dec_valid && dec.opcode[7:2] == 6'h00 |->
        dec.result_to_register == dec.opcode[1]) else $error("direction wrong");
    escape_seen_a: assert property (dec_valid |-> dec.escaped == (dec.opcode == 8'h0F))
        else $error("escape flag wrong");
    undef_slot_a: assert property (dec_valid && dec.escaped && dec.second == 8'h01 &&
        dec.reg_field == 3'h5 |-> dec.undefined) else $error("unassigned slot not flagged");
    cover property (dec_valid && dec_ready && dec.is_register);
    cover property (dec_valid && dec.undefined);
    cover property (psel && penable && pslverr);
endmodule : opad_decoder_monitor
bind opad_decoder opad_decoder_monitor opad_decoder_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pslverr(pslverr), .dec_valid(dec_valid),
    .dec_ready(dec_ready), .dec(dec));
`default_nettype wire

// File: testbench/opad_exec_model.sv
`timescale 1ns/100ps
`default_nettype none
module opad_exec_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Decode handshake and register file.
    input wire logic dec_valid,
    output logic dec_ready,
    output opad_pkg::opad_regs_t regs
);
    // Fixed register values keep every offset computable in the bench.
    assign regs = {16'h1000, 16'h2000, 16'h0030, 16'h0004};
    // Random refusals make pending decodes wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_ready <= 1'b0;
        end else begin
            dec_ready <= dec_valid & 1'($urandom_range(1, 0));
        end
    end
endmodule : opad_exec_model
`default_nettype wire

// File: testbench/opad_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module opad_decoder_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fetch_valid = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0] fetch_byte = 0, r;
    logic pready, pslverr, fetch_ready, dec_valid, dec_ready, er;
    logic [51:0] expq[$];
    opad_pkg::opad_regs_t regs;
    opad_pkg::opad_decode_t dec;
    int errors = 0, n_tests = 0;
    initial forever #20 pclk = ~pclk;
    opad_decoder opad_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .regs(regs),
        .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec(dec));
    opad_exec_model opad_exec_model_inst (.pclk(pclk), .presetn(presetn), .dec_valid(dec_valid),
        .dec_ready(dec_ready), .regs(regs));
    task automatic print_verdict();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [51:0] g, input logic [51:0] x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        for (int k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
        if (pready !== 1'b1) errors++;
        if (pready !== 1'b1) print_verdict();
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic inst(input logic [7:0] q[$], input logic [51:0] x);
        expq.push_back(x);
        foreach (q[j]) begin
            fetch_valid <= 1;
            fetch_byte <= q[j];
            @(posedge pclk);
            for (int k = 0; k < 50 && fetch_ready !== 1'b1; k++) @(posedge pclk);
            if (fetch_ready !== 1'b1) errors++;
            if (fetch_ready !== 1'b1) print_verdict();
        end
    endtask : inst
    function logic [51:0] ex(logic [15:0] l, logic [1:0] s, logic [15:0] d, logic [15:0] i);
        return {1'b1, l, s, d, i, 1'b0};
    endfunction : ex
    // Decodes are judged at the handshake edge, oldest expectation first.
    always @(posedge pclk) begin
        if (dec_valid === 1'b1 && dec_ready === 1'b1) begin
            chk({1'b1, dec.operand_location, dec.segment, dec.displacement, dec.immediate,
                dec.undefined}, expq.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        void'($urandom(32'h3d74f843));
        r = 8'($urandom);
        @(posedge pclk);
        apb(0, 12'h000, 0);
        chk(52'(rd), 52'h1);
        apb(0, 12'h020, 0);
        chk({er, 32'(rd)}, 52'h1_0000_0000);
        apb(1, 12'h000, 0);
        chk(52'(fetch_ready), 52'h0);
        apb(1, 12'h000, 1);
        inst({8'h03, 8'h47, 8'h10}, ex(16'h1010, 2'd3, 16'h0010, 0));
        inst({8'h03, 8'h46, 8'hF0}, ex(16'h1FF0, 2'd2, 16'hFFF0, 0));
        inst({8'h03, 8'h80, 8'h34, 8'h12}, ex(16'h2264, 2'd3, 16'h1234, 0));
        inst({8'h03, 8'h06, 8'h78, 8'h56}, ex(16'h5678, 2'd3, 16'h5678, 0));
        inst({8'h03, 8'h02}, ex(16'h2030, 2'd2, 0, 0));
        inst({8'h81, 8'h47, 8'h10, 8'h34, 8'h12}, ex(16'h1010, 2'd3, 16'h0010, 16'h1234));
        inst({8'h8B, 8'h45, r}, ex(16'h0004 + {{8{r[7]}}, r}, 2'd3, {{8{r[7]}}, r}, 0));
        for (int s = 0; s < 4; s++)
            inst({8'h26 | 8'(s << 3), 8'h03, 8'h07}, ex(16'h1000, 2'(s), 0, 0));
        inst({8'h2E, 8'hAA}, ex(16'h0004, 2'd0, 0, 0));
        inst({8'h83, 8'hC0, 8'hF5}, ex(0, 2'd3, 0, 16'hFFF5));
        inst({8'h0F, 8'h01, 8'h28}, ex(16'h1030, 2'd3, 0, 0) | 52'h1);
        inst({8'h8A, 8'hC4}, ex(0, 2'd3, 0, 0));
        fetch_valid <= 0;
        for (int k = 0; k < 500 && expq.size() != 0; k++) @(posedge pclk);
        if (expq.size() != 0) errors++;
        print_verdict();
    end
endmodule : opad_decoder_tb
`default_nettype wire
